// ==== hdl/dbgcc_ctrl.sv ====
// Debug command controller: command and data shifting, decode, status/control, halt line.
// Assumes TAP indications arrive in the test clock domain and core signals on clock.
//
// Overview of operation
// - Debug resources respond only while the unlock instruction is loaded.
// - Halt line assertion halts the core and enters debug mode awaiting commands.
// - Device drives the halt line low to acknowledge debug entry.
// - Halt line is open drain, shared and bidirectional.
// - Eight-bit command shift register fed from the serial data input.
// - Low five command bits select status, counters, control, data or none.
// - Further select codes map limits, latch, trace and addresses; rest reserved.
// - Leave bit acts only with execute on program data write or none.
// - Execute runs latched instruction, returning to debug unless leave is set.
// - Execute ignored except on program data write or no-register operation.
// - Command bit 7 chooses write when clear and read when set.
// - Decoder combines command, update indication and halted state into strobes.
// - Status/control register is 24 bits and clears on reset.
// - Status bit 0 enables trace operation.
// - Status bit 1 turns a debug request into a vectored interrupt.
// - Status bit 2 flags soft halt entry, cleared on leaving.
// - Status bit 3 flags breakpoint entry, cleared on leaving.
// - Status bit 4 flags trace count entry, cleared on leaving.
// - Status bit 5 and bits 8 to 23 read as zero.
// - Status bits 6-7 report running, wait, bus wait or debug.
// - Core state bits are also offered to the instruction shift register.
`timescale 1ns/100ps
module dbgcc_ctrl (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // Test port pins
    input  wire logic        tck,
    input  wire logic        tdi,
    output logic             tdo,
    // Test controller indications
    input  wire logic        unlockActive,
    input  wire logic        shiftCmd,
    input  wire logic        shiftData,
    input  wire logic        updateReg,
    // Halt request line
    input  wire logic        haltLineN_in,
    output logic             haltLineN_out,
    output logic             haltLineN_oe,
    // Core side
    input  wire logic        coreHalted,
    input  wire logic        coreInstrDone,
    input  wire logic [1:0]  coreState,
    input  wire logic        softHaltEvent,
    input  wire logic        breakpointEvent,
    input  wire logic        traceZeroEvent,
    output logic             coreHaltReq,
    output logic             coreGo,
    output logic             vectorIrq,
    output logic [7:0]       vectorOffset,
    output logic             traceEnable,
    output logic [1:0]       irStateBits,
    // Debug register strobes
    output logic [4:0]       regSelect,
    output logic             regWrite,
    output logic             regRead,
    output logic [23:0]      regWriteData,
    input  wire logic [23:0] regReadData
);

    logic [6:0]              syncVec;
    logic                    tckS;
    logic                    tdiS;
    logic                    unlockS;
    logic                    shiftCmdS;
    logic                    shiftDataS;
    logic                    updateS;
    logic                    haltS;
    logic                    tckDly_q;
    logic                    updDly_q;
    logic                    haltDly_q;
    logic                    tckRise;
    logic                    updRise;
    logic                    haltFall;
    logic [7:0]              cmdPar;
    logic [23:0]             dataPar;
    logic                    dataSerial;
    logic                    dataLoad;
    logic [23:0]             dataLoadValue;
    logic                    lastWasCmd_q;
    logic [4:0]              dataCount_q;
    logic                    awaitData_q;
    logic                    readPending_q;
    logic [7:0]              latchedCmd_q;
    logic                    cmdUpdate;
    logic                    dataUpdate;
    logic [4:0]              sel;
    logic                    selRead;
    logic                    goFire;
    logic                    goLeave;
    logic [23:0]             writeValue;
    dbgcc_pkg::dbgcc_mode_t  mode_q;
    logic [1:0]              control_q;
    logic [2:0]              causes_q;
    logic [2:0]              pending_q;
    logic [2:0]              events;
    logic [1:0]              stateBits;
    logic [23:0]             statusValue;
    logic                    entryReq;

    dbgcc_sync #(
        .WIDTH (7)
    ) u_sync (
        .clock   (clock),
        .reset   (reset),
        .asyncIn ({tck, tdi, unlockActive, shiftCmd, shiftData, updateReg, haltLineN_in}),
        .syncOut (syncVec)
    );

    assign {tckS, tdiS, unlockS, shiftCmdS, shiftDataS, updateS, haltS} = syncVec;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tckDly_q  <= 1'b0;
            updDly_q  <= 1'b0;
            haltDly_q <= 1'b0;
        end else begin
            tckDly_q  <= tckS;
            updDly_q  <= updateS;
            haltDly_q <= haltS;
        end
    end

    assign tckRise  = tckS & ~tckDly_q;
    assign updRise  = updateS & ~updDly_q;
    assign haltFall = haltDly_q & ~haltS;

    dbgcc_shift #(
        .WIDTH (dbgcc_pkg::CMD_W)
    ) u_cmd (
        .clock       (clock),
        .reset       (reset),
        .shiftEn     (tckRise & shiftCmdS & unlockS),
        .serialIn    (tdiS),
        .serialOut   (),
        .loadEn      (1'b0),
        .loadValue   (8'h00),
        .parallelOut (cmdPar)
    );

    dbgcc_shift #(
        .WIDTH (dbgcc_pkg::DATA_W)
    ) u_data (
        .clock       (clock),
        .reset       (reset),
        .shiftEn     (tckRise & shiftDataS & unlockS),
        .serialIn    (tdiS),
        .serialOut   (dataSerial),
        .loadEn      (dataLoad),
        .loadValue   (dataLoadValue),
        .parallelOut (dataPar)
    );

    // Known select codes; anything else is reserved.
    function automatic logic selKnown(input logic [4:0] code);
        case (code)
            dbgcc_pkg::SEL_STATUS, dbgcc_pkg::SEL_BP_COUNT, dbgcc_pkg::SEL_BP_CTRL,
            dbgcc_pkg::SEL_LIMIT0, dbgcc_pkg::SEL_LIMIT1, dbgcc_pkg::SEL_GLOBAL_DATA,
            dbgcc_pkg::SEL_PROG_DATA, dbgcc_pkg::SEL_INSTR_LATCH, dbgcc_pkg::SEL_GOTO,
            dbgcc_pkg::SEL_TRACE_COUNT, dbgcc_pkg::SEL_FETCH_ADDR,
            dbgcc_pkg::SEL_DECODE_ADDR, dbgcc_pkg::SEL_EXEC_ADDR,
            dbgcc_pkg::SEL_TRACE_BUF: selKnown = 1'b1;
            default: selKnown = 1'b0;
        endcase
    endfunction : selKnown

    assign cmdUpdate  = updRise & unlockS & lastWasCmd_q;
    assign dataUpdate = updRise & unlockS & ~lastWasCmd_q & awaitData_q;
    assign sel        = cmdPar[dbgcc_pkg::CMD_SEL_LSB +: dbgcc_pkg::SEL_W];
    assign selRead    = cmdPar[dbgcc_pkg::CMD_DIR_BIT];

    // Short transfers land in the top byte of the data shifter.
    assign writeValue = (dataCount_q == dbgcc_pkg::SHORT_XFER) ?
                        {16'h0000, dataPar[23:16]} : dataPar;

    // Execute is honoured only on no-register operations or program data writes.
    always_comb begin
        goFire  = 1'b0;
        goLeave = 1'b0;
        if (mode_q == dbgcc_pkg::DBG_HALTED) begin
            if (cmdUpdate && cmdPar[dbgcc_pkg::CMD_EXEC_BIT] &&
                sel == dbgcc_pkg::SEL_NONE) begin
                goFire  = 1'b1;
                goLeave = cmdPar[dbgcc_pkg::CMD_LEAVE_BIT];
            end else if (dataUpdate && latchedCmd_q[dbgcc_pkg::CMD_EXEC_BIT] &&
                         latchedCmd_q[4:0] == dbgcc_pkg::SEL_PROG_DATA) begin
                goFire  = 1'b1;
                goLeave = latchedCmd_q[dbgcc_pkg::CMD_LEAVE_BIT];
            end
        end
    end

    // Core state seen through the status register and the instruction register.
    assign stateBits = (mode_q == dbgcc_pkg::DBG_HALTED) ? dbgcc_pkg::CORE_DEBUG
                                                          : coreState;
    assign statusValue = {16'h0000, stateBits, 1'b0, causes_q, control_q};

    always_comb begin
        dataLoad      = 1'b0;
        dataLoadValue = 24'h000000;
        if (readPending_q) begin
            dataLoad      = 1'b1;
            dataLoadValue = regReadData;
        end else if (cmdUpdate && selRead) begin
            dataLoad = 1'b1;
            if (sel == dbgcc_pkg::SEL_STATUS) begin
                dataLoadValue = statusValue;
            end
        end
    end

    // Serial bookkeeping: which register shifted last and how many data bits.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            lastWasCmd_q <= 1'b0;
            dataCount_q  <= 5'h00;
        end else if (tckRise && unlockS && shiftCmdS) begin
            lastWasCmd_q <= 1'b1;
        end else if (tckRise && unlockS && shiftDataS) begin
            lastWasCmd_q <= 1'b0;
            dataCount_q  <= dataCount_q + 5'h01;
        end else if (updRise || cmdUpdate) begin
            dataCount_q  <= 5'h00;
        end
    end

    // Command decode and register strobes.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            latchedCmd_q  <= 8'h00;
            awaitData_q   <= 1'b0;
            readPending_q <= 1'b0;
            regSelect     <= dbgcc_pkg::SEL_NONE;
            regWrite      <= 1'b0;
            regRead       <= 1'b0;
            regWriteData  <= 24'h000000;
        end else begin
            regWrite      <= 1'b0;
            regRead       <= 1'b0;
            readPending_q <= regRead;
            if (cmdUpdate) begin
                latchedCmd_q <= cmdPar;
                awaitData_q  <= ~selRead && sel != dbgcc_pkg::SEL_NONE && selKnown(sel);
                if (selRead && selKnown(sel) && sel != dbgcc_pkg::SEL_STATUS) begin
                    regSelect <= sel;
                    regRead   <= 1'b1;
                end
            end else if (dataUpdate) begin
                awaitData_q <= 1'b0;
                if (latchedCmd_q[4:0] != dbgcc_pkg::SEL_STATUS) begin
                    regSelect    <= latchedCmd_q[4:0];
                    regWriteData <= writeValue;
                    regWrite     <= 1'b1;
                end
            end
        end
    end

    // Control bits of the status register; status bits are never written.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            control_q <= dbgcc_pkg::STATUS_RESET[1:0];
        end else if (dataUpdate && latchedCmd_q[4:0] == dbgcc_pkg::SEL_STATUS) begin
            control_q <= writeValue[dbgcc_pkg::ST_VECTOR:dbgcc_pkg::ST_TRACE_EN];
        end
    end

    assign events = {traceZeroEvent & control_q[dbgcc_pkg::ST_TRACE_EN],
                     breakpointEvent, softHaltEvent};
    assign entryReq = unlockS && (haltFall || (|events));

    // Entry causes are held until the core halts, then shown until debug is left.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pending_q <= 3'h0;
            causes_q  <= dbgcc_pkg::STATUS_RESET[4:2];
        end else if (mode_q == dbgcc_pkg::DBG_HALTING && coreHalted) begin
            pending_q <= 3'h0;
            causes_q  <= pending_q | events;
        end else if (mode_q == dbgcc_pkg::DBG_HALTED && goFire && goLeave) begin
            pending_q <= events;
            causes_q  <= 3'h0;
        end else if (mode_q != dbgcc_pkg::DBG_HALTED) begin
            pending_q <= pending_q | events;
        end
    end

    // Debug mode sequencing.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            mode_q       <= dbgcc_pkg::DBG_RUN;
            coreHaltReq  <= 1'b0;
            coreGo       <= 1'b0;
            vectorIrq    <= 1'b0;
            vectorOffset <= 8'h00;
        end else begin
            coreGo    <= 1'b0;
            vectorIrq <= 1'b0;
            case (mode_q)
                dbgcc_pkg::DBG_RUN: begin
                    if (entryReq && control_q[dbgcc_pkg::ST_VECTOR]) begin
                        vectorIrq    <= 1'b1;
                        vectorOffset <= dbgcc_pkg::VECTOR_OFFSET;
                    end else if (entryReq) begin
                        coreHaltReq <= 1'b1;
                        mode_q      <= dbgcc_pkg::DBG_HALTING;
                    end
                end
                dbgcc_pkg::DBG_HALTING: begin
                    if (coreHalted) begin
                        coreHaltReq <= 1'b0;
                        mode_q      <= dbgcc_pkg::DBG_HALTED;
                    end
                end
                dbgcc_pkg::DBG_HALTED: begin
                    if (goFire) begin
                        coreGo <= 1'b1;
                        mode_q <= goLeave ? dbgcc_pkg::DBG_RUN : dbgcc_pkg::DBG_EXEC;
                    end
                end
                dbgcc_pkg::DBG_EXEC: begin
                    if (coreInstrDone) begin
                        mode_q <= dbgcc_pkg::DBG_HALTED;
                    end
                end
                default: mode_q <= dbgcc_pkg::DBG_RUN;
            endcase
        end
    end

    // Acknowledge: pull the shared line low from entry until the first command.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            haltLineN_oe <= 1'b0;
        end else if (mode_q == dbgcc_pkg::DBG_HALTING && coreHalted) begin
            haltLineN_oe <= 1'b1;
        end else if (cmdUpdate || mode_q != dbgcc_pkg::DBG_HALTED) begin
            haltLineN_oe <= 1'b0;
        end
    end

    // Open drain: the driven level is always low.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            haltLineN_out <= 1'b0;
        end else begin
            haltLineN_out <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            tdo         <= 1'b0;
            traceEnable <= 1'b0;
            irStateBits <= dbgcc_pkg::CORE_RUN;
        end else begin
            tdo         <= dataSerial;
            traceEnable <= control_q[dbgcc_pkg::ST_TRACE_EN];
            irStateBits <= stateBits;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    localparam int ACK_MAX = 2;

    sequence seqRunRequest;
        mode_q == dbgcc_pkg::DBG_RUN && entryReq && !control_q[dbgcc_pkg::ST_VECTOR];
    endsequence

    sequence seqLeaveDebug;
        mode_q == dbgcc_pkg::DBG_HALTED && goFire && goLeave;
    endsequence

    AST_LOCKED: assert property (!unlockS |=> !regWrite && !regRead && !coreGo)
        else $error("Debug strobe while locked.");
    AST_HALT_SEQ: assert property (seqRunRequest |=> coreHaltReq &&
                                   mode_q == dbgcc_pkg::DBG_HALTING)
        else $error("Halt request not raised.");
    AST_HALT_ACK: assert property (mode_q == dbgcc_pkg::DBG_HALTING && coreHalted |->
                                   ##[1:ACK_MAX] haltLineN_oe)
        else $error("Debug entry not acknowledged.");
    AST_OPEN_DRAIN: assert property (haltLineN_oe |-> !haltLineN_out &&
                                     mode_q == dbgcc_pkg::DBG_HALTED)
        else $error("Halt line driven high or pulled outside debug.");
    AST_GO_HALTED: assert property (coreGo |-> $past(mode_q) == dbgcc_pkg::DBG_HALTED)
        else $error("Execute outside debug mode.");
    AST_DIR: assert property (regWrite |-> !latchedCmd_q[dbgcc_pkg::CMD_DIR_BIT])
        else $error("Write strobe on a read command.");
    AST_VECTOR: assert property (mode_q == dbgcc_pkg::DBG_RUN && entryReq &&
                                 control_q[dbgcc_pkg::ST_VECTOR] |=>
                                 vectorIrq && mode_q == dbgcc_pkg::DBG_RUN)
        else $error("Vectored request entered debug mode.");
    AST_CAUSE_CLEAR: assert property (seqLeaveDebug |=> causes_q == 3'h0 &&
                                      mode_q == dbgcc_pkg::DBG_RUN)
        else $error("Cause flags kept after leaving debug.");
    AST_STATE_DEBUG: assert property (mode_q == dbgcc_pkg::DBG_HALTED ##1
                                      mode_q == dbgcc_pkg::DBG_HALTED |->
                                      irStateBits == dbgcc_pkg::CORE_DEBUG)
        else $error("Debug state not reported.");
    AST_STATUS_ZERO: assert property (statusValue[23:8] == 16'h0000 && !statusValue[5])
        else $error("Reserved status bits not zero.");
    AST_RESERVED: assert property (regRead || regWrite |-> selKnown(regSelect))
        else $error("Strobe on a reserved select code.");

endmodule : dbgcc_ctrl

// ==== hdl/dbgcc_pkg.sv ====
// Constants, field positions and types shared by the debug command controller.
// Assumes a single core clock domain; the test port arrives asynchronously.
package dbgcc_pkg;

    // Word widths.
    localparam int CMD_W       = 8;
    localparam int DATA_W      = 24;
    localparam int SEL_W       = 5;
    localparam int CNT_W       = 5;

    // Command field positions.
    localparam int CMD_SEL_LSB   = 0;
    localparam int CMD_LEAVE_BIT = 5;
    localparam int CMD_EXEC_BIT  = 6;
    localparam int CMD_DIR_BIT   = 7;

    // Register select codes.
    localparam logic [4:0] SEL_STATUS      = 5'h00;
    localparam logic [4:0] SEL_BP_COUNT    = 5'h01;
    localparam logic [4:0] SEL_BP_CTRL     = 5'h02;
    localparam logic [4:0] SEL_LIMIT0      = 5'h05;
    localparam logic [4:0] SEL_LIMIT1      = 5'h06;
    localparam logic [4:0] SEL_GLOBAL_DATA = 5'h09;
    localparam logic [4:0] SEL_PROG_DATA   = 5'h0A;
    localparam logic [4:0] SEL_INSTR_LATCH = 5'h0B;
    localparam logic [4:0] SEL_GOTO        = 5'h0C;
    localparam logic [4:0] SEL_TRACE_COUNT = 5'h0D;
    localparam logic [4:0] SEL_FETCH_ADDR  = 5'h0F;
    localparam logic [4:0] SEL_DECODE_ADDR = 5'h10;
    localparam logic [4:0] SEL_EXEC_ADDR   = 5'h11;
    localparam logic [4:0] SEL_TRACE_BUF   = 5'h12;
    localparam logic [4:0] SEL_NONE        = 5'h1F;

    // Status and control register layout.
    localparam int ST_TRACE_EN   = 0;
    localparam int ST_VECTOR     = 1;
    localparam int ST_SOFT       = 2;
    localparam int ST_BP         = 3;
    localparam int ST_TRACE_HIT  = 4;
    localparam int ST_STATE_LSB  = 6;
    localparam logic [23:0] STATUS_RESET = 24'h000000;

    // Number of data bits in a short transfer.
    localparam logic [4:0] SHORT_XFER = 5'h08;

    // Vector offset used when a debug request is turned into an interrupt.
    localparam logic [7:0] VECTOR_OFFSET = 8'h06;

    // Core state codes.
    localparam logic [1:0] CORE_RUN   = 2'h0;
    localparam logic [1:0] CORE_WAIT  = 2'h1;
    localparam logic [1:0] CORE_BUS   = 2'h2;
    localparam logic [1:0] CORE_DEBUG = 2'h3;

    typedef enum logic [1:0] {
        DBG_RUN     = 2'b00,
        DBG_HALTING = 2'b01,
        DBG_HALTED  = 2'b10,
        DBG_EXEC    = 2'b11
    } dbgcc_mode_t;

endpackage : dbgcc_pkg

// ==== hdl/dbgcc_sync.sv ====
// Two-stage synchroniser for a group of asynchronous level inputs.
// Assumes each bit is independent; no bus coherency is implied.
`timescale 1ns/100ps
module dbgcc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             reset,
    // Levels
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_q;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            stage1_q <= '0;
            syncOut  <= '0;
        end else begin
            stage1_q <= asyncIn;
            syncOut  <= stage1_q;
        end
    end

endmodule : dbgcc_sync

// ==== hdl/dbgcc_shift.sv ====
// Serial-in shift register with parallel load and serial out at the low end.
// Assumes shift and load are never requested in the same cycle; load wins.
`timescale 1ns/100ps
module dbgcc_shift #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             reset,
    // Serial side
    input  wire logic             shiftEn,
    input  wire logic             serialIn,
    output logic                  serialOut,
    // Parallel side
    input  wire logic             loadEn,
    input  wire logic [WIDTH-1:0] loadValue,
    output logic      [WIDTH-1:0] parallelOut
);

    // Bits enter at the top, so the first bit shifted ends at bit 0.
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            parallelOut <= '0;
        end else if (loadEn) begin
            parallelOut <= loadValue;
        end else if (shiftEn) begin
            parallelOut <= {serialIn, parallelOut[WIDTH-1:1]};
        end
    end

    assign serialOut = parallelOut[0];

endmodule : dbgcc_shift

// ==== bench/dbgcc_probe.sv ====
// Far-side probe model: drives the test port pins and pulls the shared halt line.
// Assumes the bench clock paces it; tck rests low between frames.
`timescale 1ns/100ps
module dbgcc_probe (
    // Clock
    input  wire logic clock,
    // Test port
    input  wire logic tdo,
    output logic      tck,
    output logic      tdi,
    output logic      shiftCmd,
    output logic      shiftData,
    output logic      updateReg,
    // Halt line, pulled low only
    input  wire logic haltLine,
    output logic      haltReqN
);
    initial {tck, tdi, shiftCmd, shiftData, updateReg, haltReqN} = 6'h01;
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
    endtask : wt
    task automatic xfer(input logic c, input logic [23:0] v, input int n, input logic upd,
                        output logic [23:0] got);
        got = 24'h0;
        shiftCmd <= c;
        shiftData <= ~c;
        for (int i = 0; i < n; i++) begin
            tdi <= v[i];
            wt(10);
            got[i] = tdo;
            tck <= 1'b1;
            wt(10);
            tck <= 1'b0;
        end
        tdi <= ~v[n-1];
        shiftCmd <= 1'b0;
        shiftData <= 1'b0;
        if (upd) begin
            updateReg <= 1'b1;
            wt(10);
            updateReg <= 1'b0;
        end
        wt(10);
    endtask : xfer
    // The line is released before any command; a held ack shows as a low line.
    task automatic halt(output logic acked);
        haltReqN <= 1'b0;
        wt(30);
        haltReqN <= 1'b1;
        wt(2);
        acked = ~haltLine;
    endtask : halt
endmodule : dbgcc_probe

// ==== bench/dbgcc_ctrl_tb.sv ====
// Bench for the debug command controller with a probe model and a two-flop core.
// Assumes the probe model is compiled first.
`timescale 1ns/100ps
module dbgcc_ctrl_tb;
    logic clock = 0, reset = 1, unlockActive = 0, coreHalted = 0, coreInstrDone = 0;
    logic breakpointEvent = 0, tck, tdi, tdo, shiftCmd, shiftData, updateReg, haltReqN;
    logic softHaltEvent = 0, traceZeroEvent = 0;
    logic oe, drv, coreHaltReq, coreGo, vectorIrq, traceEnable, regWrite, regRead;
    logic [1:0] coreState = 0, irStateBits, st;
    logic [4:0] regSelect;
    logic [7:0] vectorOffset;
    logic [23:0] regWriteData, regReadData = 0, d;
    logic [28:0] wq[$];
    int n_errors = 0, checks = 0, nGo = 0, nIrq = 0;
    localparam logic [4:0] CODES [16] = '{5'h01, 5'h02, 5'h05, 5'h06, 5'h09, 5'h0A, 5'h0B,
        5'h0C, 5'h0D, 5'h0F, 5'h10, 5'h11, 5'h12, 5'h03, 5'h13, 5'h1F};
    wire haltLine = haltReqN & ~(oe & ~drv);
    always #4 clock = ~clock;
    dbgcc_probe u_probe (.clock(clock), .tdo(tdo), .tck(tck), .tdi(tdi), .shiftCmd(shiftCmd),
        .shiftData(shiftData), .updateReg(updateReg), .haltLine(haltLine), .haltReqN(haltReqN));
    dbgcc_ctrl u_dut (.clock(clock), .reset(reset), .tck(tck), .tdi(tdi), .tdo(tdo),
        .unlockActive(unlockActive), .shiftCmd(shiftCmd), .shiftData(shiftData),
        .updateReg(updateReg), .haltLineN_in(haltLine), .haltLineN_out(drv),
        .haltLineN_oe(oe), .coreHalted(coreHalted), .coreInstrDone(coreInstrDone),
        .coreState(coreState), .softHaltEvent(softHaltEvent), .breakpointEvent(breakpointEvent),
        .traceZeroEvent(traceZeroEvent), .coreHaltReq(coreHaltReq), .coreGo(coreGo),
        .vectorIrq(vectorIrq), .vectorOffset(vectorOffset), .traceEnable(traceEnable),
        .irStateBits(irStateBits), .regSelect(regSelect), .regWrite(regWrite),
        .regRead(regRead), .regWriteData(regWriteData), .regReadData(regReadData));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk
    // The core halts one cycle after a request and runs again on a go pulse.
    always @(posedge clock) begin
        coreHalted <= coreHaltReq | (coreHalted & ~coreGo);
        coreInstrDone <= coreGo;
        nGo += int'(coreGo === 1'b1);
        nIrq += int'(vectorIrq === 1'b1);
        if (regWrite === 1'b1) begin
            if (wq.size() == 0) chk(32'h1, 32'h0);
            else chk({regSelect, regWriteData}, wq.pop_front());
        end
    end
    task automatic wr(input logic [7:0] c, input logic [23:0] v, input int n = 24);
        logic [23:0] g;
        u_probe.xfer(1'b1, {16'h0, c}, 8, 1'b1, g);
        u_probe.xfer(1'b0, v, n, 1'b1, g);
    endtask : wr
    task automatic rd(input logic [7:0] c, input logic [23:0] e);
        logic [23:0] g;
        u_probe.xfer(1'b1, {16'h0, c}, 8, 1'b1, g);
        u_probe.xfer(1'b0, 24'($urandom), 24, 1'b0, g);
        chk(g, e);
    endtask : rd
    task automatic wrap_up;
        $display("n_errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        logic [23:0] g;
        logic ack;
        d = $urandom(63210);
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        u_probe.wt(3);
        wr(8'h02, 24'h000005);
        unlockActive <= 1'b1;
        st = 2'($urandom_range(2, 0));
        coreState <= st;
        foreach (CODES[k]) begin
            d = $urandom;
            if (!(CODES[k] inside {5'h03, 5'h13, 5'h1F})) wq.push_back({CODES[k], d});
            wr({3'h0, CODES[k]}, d);
        end
        d = $urandom;
        wq.push_back({5'h01, 16'h0000, d[7:0]});
        wr(8'h01, d, 8);
        chk(wq.size(), 0);
        wr(8'h00, 24'h000003);
        u_probe.wt(4);
        chk(traceEnable, 1'b1);
        rd(8'h80, {16'h0, st, 6'h03});
        u_probe.halt(ack);
        chk({ack, vectorOffset}, 9'h006);
        chk(nIrq, 1);
        wr(8'h00, 24'h000001);
        d = $urandom;
        regReadData <= d;
        rd(8'h85, d);
        rd(8'h83, 24'h0);
        u_probe.halt(ack);
        chk(ack, 1'b1);
        chk(irStateBits, 2'h3);
        rd(8'hE0, {16'h0, 2'h3, 6'h01});
        u_probe.xfer(1'b1, 24'h7F, 8, 1'b1, g);
        chk(nGo, 1);
        breakpointEvent <= 1'b1;
        u_probe.wt(1);
        breakpointEvent <= 1'b0;
        u_probe.wt(20);
        rd(8'h80, {16'h0, 2'h3, 6'h09});
        u_probe.xfer(1'b1, 24'h7F, 8, 1'b1, g);
        rd(8'h80, {16'h0, st, 6'h01});
        chk(nGo, 2);
        softHaltEvent <= 1'b1;
        traceZeroEvent <= 1'b1;
        u_probe.wt(1);
        softHaltEvent <= 1'b0;
        traceZeroEvent <= 1'b0;
        u_probe.wt(20);
        rd(8'h80, {16'h0, 2'h3, 6'h15});
        u_probe.xfer(1'b1, 24'h5F, 8, 1'b1, g);
        chk(nGo, 3);
        rd(8'h80, {16'h0, 2'h3, 6'h15});
        d = $urandom;
        wq.push_back({5'h0A, d});
        wr(8'h6A, d);
        chk(nGo, 4);
        rd(8'h80, {16'h0, st, 6'h01});
        wrap_up();
    end
endmodule : dbgcc_ctrl_tb
